// ===== pkg/scan_consts.vh
// constants for the per-line bit service scanner
`ifndef SCAN_CONSTS_VH
`define SCAN_CONSTS_VH
// register word offsets (address bits 7:2)
`define OFS_LINE_SEL 6'h00
`define OFS_CTRL 6'h01
`define OFS_CHAR 6'h02
`define OFS_FLAGS 6'h03
`define OFS_SHIFT 6'h04
`define OFS_FETCH 6'h05
`define OFS_TEST 6'h06
// control register field positions
`define CTRL_STATE_LSB 0
`define CTRL_NRZI_BIT 4
`define CTRL_DIAG_BIT 5
`define CTRL_BITMODE_BIT 6
// line status flag positions
`define FLG_ERR 0
`define FLG_LOCK 1
`define FLG_OVR 2
`define FLG_SPARE 3
// line control word positions (fetch word)
`define LCW_CHAR_LSB 0
`define LCW_FLG_LSB 8
`define LCW_DSR 12
`define LCW_CTS 13
`define LCW_CD 14
`define LCW_LINE_LSB 16
// line state codes
`define ST_RX 4'h7
`define ST_TX_INIT 4'h8
`define ST_TX 4'h9
`define ST_TX_TURN 4'hC
// shift field positions
`define SF_TAG_POS 2
`define SF_DONE_POS 9
`define SF_LOAD_TAG 10'h004
// bit-oriented patterns
`define PAT_FLAG 8'h7E
`define PAT_ABORT 8'h7F
`define ONES_LIMIT 3'h5
// reset values
`define RST_SHIFT 10'h000
`define RST_CHAR 8'h00
`define RST_STATE 4'h0
`define RST_FLAGS 4'h0
`endif

// ===== rtl/line_scanner.v
// per-line bit service scanner with avalon-mm register access
`timescale 1ns/1ps
`default_nettype none
`include "scan_consts.vh"

module line_scanner #(
	parameter LINES = 16,
	parameter AW = 4
) (
	input wire REF_CLK,
	input wire SRST,
	input wire [7:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output wire [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	input wire BIT_SVC,
	input wire [AW-1:0] LINE_ADDR,
	input wire RX_DATA,
	input wire CTS_IN,
	input wire CD_IN,
	output wire SEND_DATA,
	output wire [AW-1:0] SEND_LINE,
	output wire SEND_STB,
	output wire DSR_SIM,
	output wire CTS_SIM,
	output wire L2_REQ
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// merge write data into old value under byte enables
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					merge[k*8 +: 8] = wd[k*8 +: 8];
				end
			end
		end
	endfunction

	// nrzi transform: zero toggles, one keeps level
	function nrzi_map;
		input bit_in;
		input last;
		begin
			nrzi_map = bit_in ? last : ~last;
		end
	endfunction

	localparam SW = AW + 4; // synchroniser vector width

	// ------------------------------------------------------------
	// per-line storage
	// ------------------------------------------------------------
	reg [9:0] sf_mem [0:LINES-1]; // serial_shift_field
	reg [7:0] pc_mem [0:LINES-1]; // parallel_char_field
	reg [3:0] st_mem [0:LINES-1]; // line_state_code
	reg [3:0] fl_mem [0:LINES-1]; // line_status_flags
	reg [2:0] cf_mem [0:LINES-1]; // bitmode, diag, nrzi
	reg [2:0] on_mem [0:LINES-1]; // ones counter
	reg [7:0] hi_mem [0:LINES-1]; // received bit history
	reg [LINES-1:0] last_ff; // last line state
	reg [LINES-1:0] pend_ff; // second_level_interrupt pending

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	reg [SW-1:0] s1_ff, s2_ff, s3_ff; // three stage chain
	reg [SW-1:0] filt_ff; // agreed value
	reg svc_prev_ff; // strobe edge memory
	wire [SW-1:0] pins = {BIT_SVC, CD_IN, CTS_IN, RX_DATA, LINE_ADDR};

	// change counts once stages two and three agree
	always @(posedge REF_CLK) begin
		if (SRST) begin
			s1_ff <= {SW{1'b0}};
			s2_ff <= {SW{1'b0}};
			s3_ff <= {SW{1'b0}};
			filt_ff <= {SW{1'b0}};
			svc_prev_ff <= 1'b0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				filt_ff <= s3_ff;
			end
			svc_prev_ff <= filt_ff[SW-1];
		end
	end

	wire svc = filt_ff[SW-1] & ~svc_prev_ff; // one service per strobe rise
	wire cd_pin = filt_ff[SW-2];
	wire cts_pin = filt_ff[SW-3];
	wire rx_pin = filt_ff[SW-4];
	wire [AW-1:0] la = filt_ff[AW-1:0];

	// ------------------------------------------------------------
	// bit service datapath for addressed line
	// ------------------------------------------------------------
	reg test_ff; // test data latch
	wire [9:0] sf = sf_mem[la];
	wire [7:0] pc = pc_mem[la];
	wire [3:0] st = st_mem[la];
	wire [3:0] fl = fl_mem[la];
	wire nrzi = cf_mem[la][0];
	wire diag = cf_mem[la][1];
	wire bmode = cf_mem[la][2];
	wire [2:0] ones = on_mem[la];
	wire last = last_ff[la];
	wire raw_rx = diag ? test_ff : rx_pin;
	wire rx_bit = nrzi ? (raw_rx ? ~last : last) : raw_rx;
	wire tag_on = sf[`SF_DONE_POS];
	wire cts_eff = diag ? ~((st == `ST_TX_TURN) & tag_on) : cts_pin;
	wire [7:0] hist = {hi_mem[la][6:0], rx_bit};

	reg [9:0] n_sf; // nxt shift field
	reg [7:0] n_pc;
	reg [3:0] n_st;
	reg [3:0] n_fl;
	reg [2:0] n_on;
	reg n_last;
	reg n_pend;
	reg tx_bit;
	reg tx_act;

	// next per-line state on a bit service
	always @* begin
		n_sf = sf;
		n_pc = pc;
		n_st = st;
		n_fl = fl;
		n_on = ones;
		n_last = last;
		n_pend = 1'b0;
		tx_bit = 1'b1;
		tx_act = 1'b0;
		if (st == `ST_RX) begin
			n_last = raw_rx;
			if (bmode && hist == `PAT_ABORT) begin
				// abort pattern
				n_fl[`FLG_ERR] = 1'b1;
				n_fl[`FLG_LOCK] = 1'b0;
				n_sf = `RST_SHIFT;
				n_on = 3'h0;
			end else if (bmode && hist == `PAT_FLAG) begin
				// flag restarts character framing
				n_sf = `SF_LOAD_TAG;
				n_on = 3'h0;
			end else if (bmode && ones == `ONES_LIMIT && !rx_bit) begin
				n_on = 3'h0; // stuffed zero dropped
			end else if (!bmode && sf == `RST_SHIFT) begin
				// hunting start bit, no shifting
				if (!rx_bit) begin
					n_sf = `SF_LOAD_TAG;
				end
			end else if (tag_on) begin
				// character complete
				if (!bmode && !rx_bit) begin
					n_fl[`FLG_ERR] = 1'b1;
				end
				if (fl[`FLG_LOCK]) begin
					n_fl[`FLG_OVR] = 1'b1;
					n_fl[`FLG_LOCK] = 1'b0;
				end else if (!fl[`FLG_ERR] && !fl[`FLG_OVR]) begin
					n_fl[`FLG_LOCK] = 1'b1;
				end
				n_pc = {sf[6:0], 1'b0};
				n_sf = bmode ? `SF_LOAD_TAG : `RST_SHIFT;
				n_pend = 1'b1;
			end else begin
				n_sf = {sf[8:0], rx_bit};
				n_on = rx_bit ? ones + 3'h1 : 3'h0;
			end
		end else if (st == `ST_TX_INIT) begin
			// mark held until clear to send
			tx_act = 1'b1;
			tx_bit = 1'b1;
			n_last = 1'b1;
			if (cts_eff) begin
				n_st = `ST_TX;
			end
		end else if (st == `ST_TX || st == `ST_TX_TURN) begin
			tx_act = 1'b1;
			if (bmode && ones == `ONES_LIMIT) begin
				tx_bit = 1'b0; // inserted zero
				n_on = 3'h0;
			end else if (sf[8:0] == 9'h000 && tag_on) begin
				// reload from char field
				tx_bit = pc[7];
				n_sf = {pc[6:0], 3'b100};
				if (fl[`FLG_LOCK]) begin
					n_fl[`FLG_OVR] = 1'b1;
					n_fl[`FLG_LOCK] = 1'b0;
				end else begin
					n_fl[`FLG_LOCK] = 1'b1;
				end
				n_pend = 1'b1;
				n_on = pc[7] ? ones + 3'h1 : 3'h0;
			end else begin
				tx_bit = sf[9];
				n_sf = {sf[8:0], 1'b0};
				n_on = sf[9] ? ones + 3'h1 : 3'h0;
			end
			if (tx_bit != 1'b1 || st != `ST_TX_INIT) begin
				n_last = nrzi ? nrzi_map(tx_bit, last) : tx_bit;
			end
		end
	end

	// ------------------------------------------------------------
	// avalon-mm slave
	// ------------------------------------------------------------
	reg ack_ff; // answer cycle marker
	reg [31:0] rd_ff; // read data
	reg [AW-1:0] sel_ff; // selected line for register window
	reg [31:0] fetch_ff; // input register
	wire req = AVS_READ | AVS_WRITE;
	wire take = req & ~ack_ff & ~svc; // service has priority on storage
	wire [5:0] widx = AVS_ADDRESS[7:2];
	assign AVS_WAITREQUEST = req & ~ack_ff;
	assign AVS_READDATA = rd_ff;

	// lowest pending line
	reg [AW-1:0] pnd_line;
	integer j;
	always @* begin
		pnd_line = {AW{1'b0}};
		for (j = LINES - 1; j >= 0; j = j - 1) begin
			if (pend_ff[j]) begin
				pnd_line = j[AW-1:0];
			end
		end
	end

	// line control word of a line
	wire [31:0] lcw = {{(16-AW){1'b0}}, pnd_line, 1'b0, cf_mem[pnd_line][1] | 1'b0,
		cf_mem[pnd_line][1], cf_mem[pnd_line][1], fl_mem[pnd_line], pc_mem[pnd_line]};

	// register read mux
	reg [31:0] rmux;
	always @* begin
		case (widx)
			`OFS_LINE_SEL: rmux = {{(32-AW){1'b0}}, sel_ff};
			`OFS_CTRL: rmux = {25'h0, cf_mem[sel_ff], st_mem[sel_ff]};
			`OFS_CHAR: rmux = {24'h0, pc_mem[sel_ff]};
			`OFS_FLAGS: rmux = {28'h0, fl_mem[sel_ff]};
			`OFS_SHIFT: rmux = {22'h0, sf_mem[sel_ff]};
			`OFS_FETCH: rmux = fetch_ff;
			`OFS_TEST: rmux = {31'h0, test_ff};
			default: rmux = 32'h0000_0000;
		endcase
	end

	wire [31:0] wm = merge(rmux, AVS_WRITEDATA, AVS_BYTEENABLE);
	wire do_wr = take & AVS_WRITE;
	wire do_fetch = take & AVS_READ & (widx == `OFS_FETCH) & (|pend_ff);

	// ------------------------------------------------------------
	// storage update, outputs
	// ------------------------------------------------------------
	reg send_ff, stb_ff, dsr_ff, cts_ff; // line side outputs
	reg [AW-1:0] sline_ff;
	integer i;
	always @(posedge REF_CLK) begin
		if (SRST) begin
			for (i = 0; i < LINES; i = i + 1) begin
				sf_mem[i] <= `RST_SHIFT;
				pc_mem[i] <= `RST_CHAR;
				st_mem[i] <= `RST_STATE;
				fl_mem[i] <= `RST_FLAGS;
				cf_mem[i] <= 3'h0;
				on_mem[i] <= 3'h0;
				hi_mem[i] <= 8'h00;
			end
			last_ff <= {LINES{1'b1}};
			pend_ff <= {LINES{1'b0}};
			ack_ff <= 1'b0;
			rd_ff <= 32'h0000_0000;
			sel_ff <= {AW{1'b0}};
			fetch_ff <= 32'h0000_0000;
			test_ff <= 1'b1;
			send_ff <= 1'b1;
			stb_ff <= 1'b0;
			dsr_ff <= 1'b0;
			cts_ff <= 1'b0;
			sline_ff <= {AW{1'b0}};
		end else begin
			ack_ff <= take;
			stb_ff <= svc & tx_act;
			if (take) begin
				rd_ff <= rmux;
			end
			if (do_fetch) begin
				// interrupt taken: gate control word in
				fetch_ff <= lcw;
				rd_ff <= lcw;
				pend_ff[pnd_line] <= 1'b0;
			end
			if (do_wr) begin
				case (widx)
					`OFS_LINE_SEL: sel_ff <= wm[AW-1:0];
					`OFS_CTRL: begin
						st_mem[sel_ff] <= wm[3:0];
						cf_mem[sel_ff] <= wm[6:4];
					end
					`OFS_CHAR: pc_mem[sel_ff] <= wm[7:0];
					`OFS_FLAGS: fl_mem[sel_ff] <= fl_mem[sel_ff] & ~wm[3:0];
					`OFS_SHIFT: sf_mem[sel_ff] <= wm[9:0];
					default: sel_ff <= sel_ff;
				endcase
			end
			if (svc) begin
				// write back per-line fields
				sf_mem[la] <= n_sf;
				pc_mem[la] <= n_pc;
				st_mem[la] <= n_st;
				fl_mem[la] <= n_fl;
				on_mem[la] <= n_on;
				hi_mem[la] <= (st == `ST_RX) ? hist : hi_mem[la];
				last_ff[la] <= n_last;
				if (n_pend) begin
					pend_ff[la] <= 1'b1;
				end
				if (tx_act) begin
					send_ff <= n_last;
					sline_ff <= la;
					if (diag) begin
						test_ff <= tx_bit;
					end
				end
				dsr_ff <= diag;
				cts_ff <= cts_eff;
			end
		end
	end

	assign SEND_DATA = send_ff;
	assign SEND_LINE = sline_ff;
	assign SEND_STB = stb_ff;
	assign DSR_SIM = dsr_ff;
	assign CTS_SIM = cts_ff;
	assign L2_REQ = |pend_ff;
	wire unused_cd = cd_pin; // carrier pin unused; carrier bit of the control word follows diag

endmodule
`default_nettype wire

// ===== tb/line_scanner_assertions.sv
// port checker for the line scanner
`timescale 1ns/1ps
`default_nettype none
module line_scanner_assertions (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic BIT_SVC,
	input wire logic SEND_DATA,
	input wire logic SEND_STB,
	input wire logic DSR_SIM,
	input wire logic CTS_SIM,
	input wire logic L2_REQ
);
	// ------
	// one domain, reset masks every check
	// ------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	bus_answer_a:
		assert property ((AVS_READ || AVS_WRITE) |-> ##[0:20] !AVS_WAITREQUEST)
		else $error("bus answer late");
	idle_wait_a:
		assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
		else $error("wait without request");
	read_stands_a:
		assert property (!$stable(AVS_READDATA) |-> $past(AVS_READ || AVS_WRITE))
		else $error("read data moved");
	stb_pulse_a:
		assert property (SEND_STB |=> !SEND_STB) else $error("strobe too long");
	send_moves_a:
		assert property (!$stable(SEND_DATA) |-> SEND_STB) else $error("send data off service");
	cts_svc_a:
		assert property (!$stable(CTS_SIM) |-> BIT_SVC) else $error("clear to send off service");
	dsr_svc_a:
		assert property (!$stable(DSR_SIM) |-> BIT_SVC) else $error("set ready off service");
	irq_rise_a:
		assert property ($rose(L2_REQ) |-> BIT_SVC) else $error("interrupt off service");
	irq_fall_a:
		assert property ($fell(L2_REQ) |-> $past(AVS_READ)) else $error("interrupt lost");
endmodule
`default_nettype wire

// ===== tb/line_iface_model.sv
// line interface model that paces bit services
`timescale 1ns/1ps
`default_nettype none
module line_iface_model (
	input wire logic clk,
	output logic svc,
	output logic [3:0] line,
	output logic rx,
	output logic cts,
	output logic cd
);
	// idle: no service, mark on the line
	initial begin
		svc = 1'b0;
		line = 4'h0;
		rx = 1'b1;
		cts = 1'b0;
		cd = 1'b0;
	end
	// one bit service; address and data settle before the strobe
	task automatic serve(input logic [3:0] ln, input logic b);
		@(posedge clk);
		line <= ln;
		rx <= b;
		@(posedge clk);
		svc <= 1'b1;
		repeat (8) @(posedge clk);
		svc <= 1'b0;
		repeat (4) @(posedge clk);
		line <= ~ln;
		rx <= ~b;
	endtask
endmodule
`default_nettype wire

// ===== tb/scanner_line_bit_control_tb_top.sv
// bench for the line scanner
`timescale 1ns/1ps
`default_nettype none
`include "scan_consts.vh"
`define CHK(nm, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("[ERR] %s exp %h got %h", nm, exp, got); \
	end \
end
module scanner_line_bit_control_tb_top;
	logic REF_CLK = 1'b0;
	logic SRST = 1'b1;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	wire logic [31:0] AVS_READDATA;
	wire logic AVS_WAITREQUEST, BIT_SVC, RX_DATA, CTS_IN, CD_IN;
	wire logic [3:0] LINE_ADDR, SEND_LINE;
	wire logic SEND_DATA, SEND_STB, DSR_SIM, CTS_SIM, L2_REQ;
	logic [31:0] rdv;
	logic s0;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	line_scanner dut (.REF_CLK(REF_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .BIT_SVC(BIT_SVC), .LINE_ADDR(LINE_ADDR),
		.RX_DATA(RX_DATA), .CTS_IN(CTS_IN), .CD_IN(CD_IN), .SEND_DATA(SEND_DATA),
		.SEND_LINE(SEND_LINE), .SEND_STB(SEND_STB), .DSR_SIM(DSR_SIM),
		.CTS_SIM(CTS_SIM), .L2_REQ(L2_REQ));
	line_iface_model lim (.clk(REF_CLK), .svc(BIT_SVC), .line(LINE_ADDR), .rx(RX_DATA),
		.cts(CTS_IN), .cd(CD_IN));
	// ------
	// clock, hang guard, verdict
	// ------
	initial begin
		forever #20 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one bus cycle held until waitrequest is seen low
	task automatic acc(input logic wr, input logic [5:0] w, input logic [31:0] d);
		@(posedge REF_CLK);
		AVS_ADDRESS <= {w, 2'b00};
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
		rdv = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_reset();
		acc(1'b1, 6'h07, 32'hFFFF_FFFF);
		for (int w = 1; w < 8; w++) begin
			if (w != 5 && w != 6) begin
				acc(1'b0, w[5:0], 32'h0000_0000);
				`CHK("reset word", 32'h0000_0000, rdv)
			end
		end
		`CHK("idle send", 1'b1, SEND_DATA)
	endtask
	// two start-stop characters, second with bad stop and no service
	task automatic t_rx_char();
		acc(1'b1, `OFS_LINE_SEL, 32'h0000_0002);
		acc(1'b1, `OFS_CTRL, {28'h000_0000, `ST_RX});
		lim.serve(4'h2, 1'b1);
		acc(1'b0, `OFS_SHIFT, 32'h0000_0000);
		`CHK("idle shift", 10'h000, rdv[9:0])
		lim.serve(4'h2, 1'b0);
		acc(1'b0, `OFS_SHIFT, 32'h0000_0000);
		`CHK("tag load", `SF_LOAD_TAG, rdv[9:0])
		for (int i = 0; i < 7; i++) lim.serve(4'h2, 1'b1);
		acc(1'b0, `OFS_SHIFT, 32'h0000_0000);
		`CHK("tag nine", 10'h27F, rdv[9:0])
		lim.serve(4'h2, 1'b1);
		acc(1'b0, `OFS_CHAR, 32'h0000_0000);
		`CHK("char one", 8'hFE, rdv[7:0])
		acc(1'b0, `OFS_FLAGS, 32'h0000_0000);
		`CHK("flags one", 4'h2, rdv[3:0])
		`CHK("irq up", 1'b1, L2_REQ)
		acc(1'b0, `OFS_FETCH, 32'h0000_0000);
		`CHK("fetch", 12'h2FE, {rdv[19:16], rdv[7:0]})
		`CHK("irq down", 1'b0, L2_REQ)
		for (int i = 0; i < 9; i++) lim.serve(4'h2, 1'b0);
		acc(1'b0, `OFS_CHAR, 32'h0000_0000);
		`CHK("char two", 8'h00, rdv[7:0])
		acc(1'b0, `OFS_FLAGS, 32'h0000_0000);
		`CHK("flags two", 4'h5, rdv[3:0])
		acc(1'b0, `OFS_FETCH, 32'h0000_0000);
	endtask
	// wrapped receive line shows simulated modem status
	task automatic t_diag();
		acc(1'b1, `OFS_LINE_SEL, 32'h0000_0003);
		acc(1'b1, `OFS_CTRL, 32'h0000_0027); // receive line set first
		lim.serve(4'h3, 1'b1);
		`CHK("ready", 2'b11, {DSR_SIM, CTS_SIM})
		lim.serve(4'h2, 1'b1);
		`CHK("plain line", 2'b00, {DSR_SIM, CTS_SIM})
	endtask
	// coded transmit: mark hold, clear to send, zero toggles
	task automatic t_nrzi();
		acc(1'b1, `OFS_LINE_SEL, 32'h0000_0004);
		acc(1'b1, `OFS_CTRL, 32'h0000_0018);
		lim.serve(4'h4, 1'b1);
		`CHK("mark hold", 1'b1, SEND_DATA)
		@(posedge REF_CLK);
		lim.cts <= 1'b1;
		lim.serve(4'h4, 1'b1);
		acc(1'b0, `OFS_CTRL, 32'h0000_0000);
		`CHK("state nine", `ST_TX, rdv[3:0])
		s0 = SEND_DATA;
		lim.serve(4'h4, 1'b1);
		`CHK("zero flips", ~s0, SEND_DATA)
		`CHK("send line", 4'h4, SEND_LINE)
		lim.cts <= 1'b0;
	endtask
	// zero then seven ones aborts the frame
	task automatic t_abort();
		acc(1'b1, `OFS_LINE_SEL, 32'h0000_0005);
		acc(1'b1, `OFS_CTRL, 32'h0000_0047);
		lim.serve(4'h5, 1'b0);
		for (int i = 0; i < 7; i++) lim.serve(4'h5, 1'b1);
		acc(1'b0, `OFS_FLAGS, 32'h0000_0000);
		`CHK("abort", 2'b01, rdv[1:0])
		acc(1'b1, `OFS_LINE_SEL, 32'h0000_0002);
		acc(1'b0, `OFS_CTRL, 32'h0000_0000);
		`CHK("line kept", `ST_RX, rdv[3:0])
	endtask
	initial begin
		repeat (5) @(posedge REF_CLK);
		SRST <= 1'b0;
		t_reset();
		t_rx_char();
		t_diag();
		t_nrzi();
		t_abort();
		final_report();
	end
endmodule
bind line_scanner line_scanner_assertions chk (.REF_CLK(REF_CLK), .SRST(SRST),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .BIT_SVC(BIT_SVC), .SEND_DATA(SEND_DATA),
	.SEND_STB(SEND_STB), .DSR_SIM(DSR_SIM), .CTS_SIM(CTS_SIM), .L2_REQ(L2_REQ));
`default_nettype wire
